// *** bench/tb_zero_cross_detect_logic.sv ***
// Self-checking bench for the zero-cross detector logic.
// Assumes the front-end model and the design files are compiled first.
module tb_zero_cross_detect_logic;
  timeunit 1ns;
  timeprecision 1ps;
  import zx_pkg::*;

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sink_active;
  logic        above_ref = 1'b0;
  logic        strap = 1'b0;
  logic        pgate = 1'b0;
  logic        ggate = 1'b0;
  logic        zc_output_level;
  logic        pin_force_src_sink;
  logic        irq;
  int          fails = 0;
  int          cmp_count = 0;
  logic [31:0] rdat;
  logic        rerr;

  // The clock toggles every half period of 2 ns.
  always #2 clk = ~clk;

  zx_front_model FE
  (
    .clk         (clk),
    .resetn      (resetn),
    .above_ref   (above_ref),
    .sink_active (sink_active)
  );

  zx_top DUT
  (
    .clk                   (clk),
    .resetn                (resetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .sink_active           (sink_active),
    .zc_por_default_config (strap),
    .peripheral_int_gate   (pgate),
    .global_int_gate       (ggate),
    .zc_output_level       (zc_output_level),
    .pin_force_src_sink    (pin_force_src_sink),
    .irq                   (irq)
  );

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  // Waits some edges and lets their updates land.
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One APB transfer: setup, then access until pready at an edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      chk("pready", 32'h1, 32'h0);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads one register and compares the word.
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask

  // Applies reset for four cycles with the given strap level.
  task automatic do_reset(input logic s);
    strap <= s;
    resetn <= 1'b0;
    wt(4);
    resetn <= 1'b1;
    wt(3);
  endtask

  // Reset defaults and the pin drive mode.
  task automatic t_reset;
    rd(ZX_CTRL_OFF, 32'h80, "ctrl_por");
    chk("pin_force", 32'h1, {31'h0, pin_force_src_sink});
    rd(ZX_STAT_OFF, 32'h0, "status_por");
    rd(ZX_INTEN_OFF, 32'h0, "inten_por");
    apb(1'b1, ZX_CTRL_OFF, 32'h0);
    wt(2);
    chk("pin_normal", 32'h0, {31'h0, pin_force_src_sink});
    apb(1'b1, ZX_CTRL_OFF, 32'h80);
    wt(2);
    $display("test reset done");
  endtask

  // Level, polarity and the two edge detectors.
  task automatic t_edges;
    above_ref <= 1'b1;
    wt(5);
    chk("level_sink", 32'h1, {31'h0, zc_output_level});
    rd(ZX_STAT_OFF, 32'h2, "rise_no_en");
    rd(ZX_CTRL_OFF, 32'ha0, "ctrl_level");
    apb(1'b1, ZX_CLR_OFF, 32'h7);
    rd(ZX_STAT_OFF, 32'h0, "cleared");
    apb(1'b1, ZX_CTRL_OFF, 32'h93);
    wt(4);
    chk("level_inv", 32'h0, {31'h0, zc_output_level});
    rd(ZX_STAT_OFF, 32'h5, "fall_by_pol");
    apb(1'b1, ZX_CLR_OFF, 32'h7);
    apb(1'b1, ZX_CTRL_OFF, 32'h03);
    wt(4);
    rd(ZX_STAT_OFF, 32'h3, "pol_edge_off");
    $display("test edges done");
  endtask

  // Interrupt gating by enable and both outside gates.
  task automatic t_irq;
    pgate <= 1'b1;
    ggate <= 1'b0;
    apb(1'b1, ZX_INTEN_OFF, 32'h1);
    wt(3);
    chk("irq_gg_off", 32'h0, {31'h0, irq});
    ggate <= 1'b1;
    wt(3);
    chk("irq_on", 32'h1, {31'h0, irq});
    pgate <= 1'b0;
    wt(3);
    chk("irq_pg_off", 32'h0, {31'h0, irq});
    pgate <= 1'b1;
    apb(1'b1, ZX_INTEN_OFF, 32'h0);
    wt(3);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, ZX_INTEN_OFF, 32'h1);
    apb(1'b1, ZX_CLR_OFF, 32'h7);
    wt(3);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    // Enable only the any-fall status bit, then make a fall and a rise.
    apb(1'b1, ZX_INTEN_OFF, 32'h4);
    above_ref <= 1'b0;
    wt(5);
    chk("irq_fall_st", 32'h1, {31'h0, irq});
    apb(1'b1, ZX_CLR_OFF, 32'h7);
    above_ref <= 1'b1;
    wt(5);
    chk("irq_rise_masked", 32'h0, {31'h0, irq});
    $display("test irq done");
  endtask

  // An enabled edge landing with a clear keeps the flag.
  task automatic t_set_wins;
    apb(1'b1, ZX_CTRL_OFF, 32'h83);
    above_ref <= 1'b0;
    wt(5);
    @(posedge clk);
    above_ref <= 1'b1;
    apb(1'b1, ZX_CLR_OFF, 32'h7);
    wt(3);
    rd(ZX_STAT_OFF, 32'h3, "set_wins");
    $display("test set_wins done");
  endtask

  // Refused accesses: unmapped, read-only and write-only places.
  task automatic t_refuse;
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("unmapped_data", 32'h0, rdat);
    apb(1'b1, ZX_STAT_OFF, 32'h0);
    rd(ZX_STAT_OFF, 32'h3, "status_ro");
    rd(ZX_CLR_OFF, 32'h0, "clear_wo");
    do_reset(1'b1);
    rd(ZX_CTRL_OFF, 32'h20, "ctrl_strap");
    chk("pin_strap", 32'h0, {31'h0, pin_force_src_sink});
    $display("test refuse done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence of scenarios.
  initial
  begin
    do_reset(1'b0);
    t_reset;
    t_edges;
    t_irq;
    t_set_wins;
    t_refuse;
    test_done;
  end

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    #20000;
    fails++;
    test_done;
  end
endmodule

// *** bench/zx_front_model.sv ***
// Behavioural model of the analog comparator front end.
// Assumes one system clock; the pin voltage is given as a level.
module zx_front_model
(
  input  wire logic clk,         // System clock.
  input  wire logic resetn,      // Asynchronous reset, active low.
  input  wire logic above_ref,   // Pin voltage above the reference.
  output logic      sink_active  // Sink on (1) or source on (0).
);
  timeunit 1ns;
  timeprecision 1ps;

  // sink above reference
  // The front end sinks above the reference and sources below it,
  // settled on the clock so the logic sees a synchronous level.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sink_active <= 1'b0;
    else
      sink_active <= above_ref;
  end
endmodule

// *** verilog/zx_edge_det.sv ***
// Registered polarity-adjusted level and its edge detectors.
// Assumes the front-end input is synchronous to clk.
module zx_edge_det
(
  input wire logic clk,     // System clock.
  input wire logic resetn,  // Asynchronous reset, active low.
  zx_edge_if.det   edge_if  // Level and edges to the register block.
);
  import zx_pkg::*;

  logic level_ff;
  logic prev_ff;

  // Sample the adjusted output and keep its previous value.
  // registered comparator
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      level_ff <= ZX_EDGE_RST;
      prev_ff  <= ZX_EDGE_RST;
    end
    else
    begin
      level_ff <= edge_if.sink_active ^ edge_if.pol_invert;
      prev_ff  <= level_ff;
    end
  end

  // Edges come from the registered values only.
  // separate edge detectors
  assign edge_if.level = level_ff;
  assign edge_if.rise  = level_ff & ~prev_ff;
  assign edge_if.fall  = ~level_ff & prev_ff;

  AST_EDGE_EXCL : assert property (
    @(posedge clk) disable iff (!resetn)
    !(edge_if.rise && edge_if.fall))
    else $error("Rise and fall fired together.");

  AST_LEVEL_REG : assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 level_ff == $past(edge_if.sink_active ^ edge_if.pol_invert))
    else $error("Level did not follow the sampled input.");

endmodule

// *** verilog/zx_edge_if.sv ***
// Signals between the register block and the edge detector.
// Assumes both ends run on the same clock.
interface zx_edge_if;
  logic sink_active;  // Front end reports the sink is active.
  logic pol_invert;   // Polarity invert setting.
  logic level;        // Registered polarity-adjusted output.
  logic rise;         // Rising edge of level.
  logic fall;         // Falling edge of level.

  modport det
  (
    input  sink_active,
    input  pol_invert,
    output level,
    output rise,
    output fall
  );

  modport ctl
  (
    output sink_active,
    output pol_invert,
    input  level,
    input  rise,
    input  fall
  );
endinterface

// *** verilog/zx_pkg.sv ***
// Constants shared by the zero-cross detector logic.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
package zx_pkg;

  // Register byte addresses.
  localparam logic [7:0] ZX_CTRL_OFF   = 8'h00;
  localparam logic [7:0] ZX_STAT_OFF   = 8'h04;
  localparam logic [7:0] ZX_CLR_OFF    = 8'h08;
  localparam logic [7:0] ZX_INTEN_OFF  = 8'h0c;

  // Control register field positions.
  localparam int ZX_CTRL_EN_BIT    = 7;
  localparam int ZX_CTRL_OUT_BIT   = 5;
  localparam int ZX_CTRL_POL_BIT   = 4;
  localparam int ZX_CTRL_RISE_BIT  = 1;
  localparam int ZX_CTRL_FALL_BIT  = 0;

  // Status, clear and enable share one layout.
  localparam int ZX_ST_FLAG_BIT    = 0;
  localparam int ZX_ST_RISE_BIT    = 1;
  localparam int ZX_ST_FALL_BIT    = 2;
  localparam int ZX_ST_W           = 3;

  // Reset values.
  localparam logic              ZX_POL_RST   = 1'b0;
  localparam logic              ZX_EDGE_RST  = 1'b0;
  localparam logic              ZX_EN_RST    = 1'b0;
  localparam logic [ZX_ST_W-1:0] ZX_ST_RST   = 3'h0;
  localparam logic [31:0]       ZX_RDATA_RST = 32'h0000_0000;

  // Answer state of the bus slave.
  typedef enum logic [1:0] {
    ZX_BUS_IDLE = 2'b01,
    ZX_BUS_ACK  = 2'b10
  } zx_bus_e;

endpackage

// *** verilog/zx_top.sv ***
// Zero-cross detector logic: APB registers, edge flags, interrupt.
// Assumes an analog front end driving sink_active synchronously to clk
// and an outside controller supplying the two interrupt gates.

module zx_top
(
  input  wire logic        clk,                   // System clock.
  input  wire logic        resetn,                // Async reset, low.
  input  wire logic        psel,                  // APB select.
  input  wire logic        penable,               // APB access phase.
  input  wire logic        pwrite,                // APB write.
  input  wire logic [7:0]  paddr,                 // APB byte address.
  input  wire logic [31:0] pwdata,                // APB write data.
  output logic      [31:0] prdata,                // APB read data.
  output logic             pready,                // APB ready.
  output logic             pslverr,               // APB error.
  input  wire logic        sink_active,           // Sink is on.
  input  wire logic        zc_por_default_config, // Config strap.
  input  wire logic        peripheral_int_gate,   // Peripheral gate.
  input  wire logic        global_int_gate,       // Global gate.
  output logic             zc_output_level,       // Adjusted level.
  output logic             pin_force_src_sink,    // Pin drive mode.
  output logic             irq                    // Interrupt level.
);
  import zx_pkg::*;

  zx_edge_if edge_bus ();

  logic                zc_detect_enable_ff;
  logic                zc_polarity_invert_ff;
  logic                zc_rise_int_en_ff;
  logic                zc_fall_int_en_ff;
  logic [ZX_ST_W-1:0]  status_ff;
  logic [ZX_ST_W-1:0]  nxt_status;
  logic [ZX_ST_W-1:0]  int_en_ff;
  logic                init_pending_ff;
  logic                irq_ff;
  logic                pin_force_ff;
  zx_bus_e             bus_ff;
  logic [31:0]         prdata_ff;
  logic                pslverr_ff;
  logic                setup_cyc;
  logic                wr_cyc;
  logic                clr_cyc;
  logic                ctrl_wr;
  logic                set_flag;
  logic [ZX_ST_W-1:0]  set_vec;
  logic [ZX_ST_W-1:0]  clr_vec;

  // Returns true when the address names a mapped register.
  function automatic logic zx_mapped(input logic [7:0] a);
    zx_mapped = (a == ZX_CTRL_OFF) || (a == ZX_STAT_OFF) ||
                (a == ZX_CLR_OFF)  || (a == ZX_INTEN_OFF);
  endfunction

  // Read value for an address; the clear register reads as zero.
  function automatic logic [31:0] zx_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      ZX_CTRL_OFF:
      begin
        v[ZX_CTRL_EN_BIT]   = zc_detect_enable_ff;
        v[ZX_CTRL_OUT_BIT]  = edge_bus.level;
        v[ZX_CTRL_POL_BIT]  = zc_polarity_invert_ff;
        v[ZX_CTRL_RISE_BIT] = zc_rise_int_en_ff;
        v[ZX_CTRL_FALL_BIT] = zc_fall_int_en_ff;
      end
      ZX_STAT_OFF:  v[ZX_ST_W-1:0] = status_ff;
      ZX_INTEN_OFF: v[ZX_ST_W-1:0] = int_en_ff;
      default:      v = 32'h0000_0000;
    endcase
    zx_read = v;
  endfunction

  // Detector instance working on the adjusted output.
  zx_edge_det u_edge
  (
    .clk     (clk),
    .resetn  (resetn),
    .edge_if (edge_bus.det)
  );

  // The front end's sink state and polarity feed the detector.
  // sink state input
  assign edge_bus.sink_active = sink_active;
  assign edge_bus.pol_invert  = zc_polarity_invert_ff;

  // Bus phase decode; a write lands only on the ready edge.
  assign setup_cyc = psel && !penable;
  assign wr_cyc    = psel && penable && pready && pwrite;
  assign ctrl_wr   = wr_cyc && (paddr == ZX_CTRL_OFF);
  assign clr_cyc   = wr_cyc && (paddr == ZX_CLR_OFF);
  assign clr_vec   = clr_cyc ? pwdata[ZX_ST_W-1:0] : ZX_ST_RST;

  // Ready rises in the first access cycle, so every access takes two.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_ff     <= ZX_BUS_IDLE;
      prdata_ff  <= ZX_RDATA_RST;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      case (bus_ff)
        ZX_BUS_IDLE:
        begin
          if (setup_cyc)
          begin
            bus_ff     <= ZX_BUS_ACK;
            prdata_ff  <= pwrite ? ZX_RDATA_RST : zx_read(paddr);
            pslverr_ff <= !zx_mapped(paddr);
          end
        end
        ZX_BUS_ACK:
        begin
          bus_ff     <= ZX_BUS_IDLE;
          prdata_ff  <= ZX_RDATA_RST;
          pslverr_ff <= 1'b0;
        end
        default:
        begin
          bus_ff <= ZX_BUS_IDLE;
        end
      endcase
    end
  end

  assign pready  = (bus_ff == ZX_BUS_ACK);
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  // Control bits written by software.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      zc_polarity_invert_ff <= ZX_POL_RST;
      zc_rise_int_en_ff     <= ZX_EDGE_RST;
      zc_fall_int_en_ff     <= ZX_EDGE_RST;
    end
    else if (ctrl_wr)
    begin
      zc_polarity_invert_ff <= pwdata[ZX_CTRL_POL_BIT];
      zc_rise_int_en_ff     <= pwdata[ZX_CTRL_RISE_BIT];
      zc_fall_int_en_ff     <= pwdata[ZX_CTRL_FALL_BIT];
    end
  end

  // Detect enable: the strap is caught on the first edge after reset.
  // power-on default
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      zc_detect_enable_ff <= ZX_EN_RST;
      init_pending_ff     <= 1'b1;
    end
    else if (init_pending_ff)
    begin
      zc_detect_enable_ff <= !zc_por_default_config;
      init_pending_ff     <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      zc_detect_enable_ff <= pwdata[ZX_CTRL_EN_BIT];
    end
  end

  // Pin drive mode follows the enable, one cycle later.
  // force source/sink
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_force_ff <= ZX_EN_RST;
    end
    else
    begin
      pin_force_ff <= zc_detect_enable_ff;
    end
  end

  // Edges on the adjusted output set the flag only through their own enables; a
  // polarity write flips the level and so shows up as an edge too.
  // adjusted output edges
  assign set_flag = (edge_bus.rise && zc_rise_int_en_ff) ||
                    (edge_bus.fall && zc_fall_int_en_ff);

  always_comb
  begin
    set_vec                 = ZX_ST_RST;
    set_vec[ZX_ST_FLAG_BIT] = set_flag;
    set_vec[ZX_ST_RISE_BIT] = edge_bus.rise;
    set_vec[ZX_ST_FALL_BIT] = edge_bus.fall;
  end

  // Sticky status: only software clears it, and a set wins the clear.
  // software clear only
  assign nxt_status = (status_ff & ~clr_vec) | set_vec;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_ff <= ZX_ST_RST;
    end
    else
    begin
      status_ff <= nxt_status;
    end
  end

  // Interrupt enable register, same layout as the status.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      int_en_ff <= ZX_ST_RST;
    end
    else if (wr_cyc && (paddr == ZX_INTEN_OFF))
    begin
      int_en_ff <= pwdata[ZX_ST_W-1:0];
    end
  end

  // Interrupt level; nothing here depends on sleep, so it runs on.
  // full gate chain
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= (|(status_ff & int_en_ff)) && peripheral_int_gate &&
                global_int_gate;
    end
  end

  // Outputs straight from flip-flops.
  // output level
  assign zc_output_level    = edge_bus.level;
  assign pin_force_src_sink = pin_force_ff;
  assign irq                = irq_ff;

  AST_LEVEL_NORMAL : assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 ($past(zc_polarity_invert_ff) == 1'b0) |->
      zc_output_level == $past(sink_active))
    else $error("Level wrong with polarity clear.");

  AST_LEVEL_INVERT : assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 ($past(zc_polarity_invert_ff) == 1'b1) |->
      zc_output_level == !$past(sink_active))
    else $error("Level wrong with polarity set.");

  AST_RISE_SETS : assert property (
    @(posedge clk) disable iff (!resetn)
    (edge_bus.rise && zc_rise_int_en_ff) |=> status_ff[ZX_ST_FLAG_BIT])
    else $error("Enabled rise did not set the flag.");

  AST_FALL_SETS : assert property (
    @(posedge clk) disable iff (!resetn)
    (edge_bus.fall && zc_fall_int_en_ff) |=> status_ff[ZX_ST_FLAG_BIT])
    else $error("Enabled fall did not set the flag.");

  AST_NO_SPURIOUS : assert property (
    @(posedge clk) disable iff (!resetn)
    (!status_ff[ZX_ST_FLAG_BIT] && !set_flag) |=>
      !status_ff[ZX_ST_FLAG_BIT])
    else $error("Flag set without an enabled edge.");

  AST_SET_WINS : assert property (
    @(posedge clk) disable iff (!resetn)
    (set_flag && clr_cyc && pwdata[ZX_ST_FLAG_BIT]) |=>
      status_ff[ZX_ST_FLAG_BIT])
    else $error("Clear beat a simultaneous edge.");

  AST_FLAG_STICKY : assert property (
    @(posedge clk) disable iff (!resetn)
    (status_ff[ZX_ST_FLAG_BIT] && !clr_cyc) |=>
      status_ff[ZX_ST_FLAG_BIT])
    else $error("Flag dropped without a software clear.");

  AST_IRQ_GATES : assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 irq == ($past(|(status_ff & int_en_ff)) &&
                $past(peripheral_int_gate) && $past(global_int_gate)))
    else $error("Interrupt does not match its gates.");

  AST_POL_EVENT : assert property (
    @(posedge clk) disable iff (!resetn)
    ($changed(zc_polarity_invert_ff) && $stable(sink_active)) |=>
      (edge_bus.rise || edge_bus.fall))
    else $error("Polarity change gave no edge.");

  AST_FORCE_PIN : assert property (
    @(posedge clk) disable iff (!resetn)
    ##1 pin_force_src_sink == $past(zc_detect_enable_ff))
    else $error("Pin mode does not follow enable.");

  AST_POR_DEFAULT : assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(init_pending_ff) |->
      zc_detect_enable_ff == !$past(zc_por_default_config))
    else $error("Enable not loaded from the strap.");

  AST_READY_ONE : assert property (
    @(posedge clk) disable iff (!resetn)
    pready |=> !pready)
    else $error("Ready held for more than one cycle.");

endmodule
